// File: logic/irq_regs_pkg.sv
// Purpose: constants and carriers for the peripheral interrupt enable/flag registers
// Assumes: 32-bit Avalon-MM word registers, byte addresses
// Notes:   one definition per number; design files refer to them with the package scope
package irq_regs_pkg;

  // register byte addresses
  localparam logic [3:0] ADDR_PROT_EN   = 4'h0; // protection_irq_enable
  localparam logic [3:0] ADDR_SER_FLAGS = 4'h4; // serial_timer_irq_flags
  localparam logic [3:0] ADDR_GLOBAL    = 4'h8; // global_irq_control
  localparam logic [3:0] ADDR_SER_EN    = 4'hC; // serial/timer enables

  // reset values
  localparam logic [7:0] PROT_EN_RST    = 8'h00;
  localparam logic [7:0] SER_FLAGS_RST  = 8'h00;
  localparam logic [7:0] SER_EN_RST     = 8'h00;
  localparam logic [1:0] GLOBAL_RST     = 2'h0;

  // implemented bits of the protection enable register: bit 5 absent
  localparam logic [7:0] PROT_EN_MASK   = 8'hDF;

  // protection enable bit positions
  localparam int BIT_DESATURATION_DETECT   = 7;
  localparam int BIT_CONV    = 6;
  localparam int BIT_OTEMP   = 4;
  localparam int BIT_OUT_OV  = 3;
  localparam int BIT_GD_UV   = 2;
  localparam int BIT_IN_OV   = 1;
  localparam int BIT_IN_UV   = 0;

  // serial/timer flag bit positions
  localparam int BIT_TX      = 7;
  localparam int BIT_RX      = 6;
  localparam int BIT_BCOL    = 5;
  localparam int BIT_SSP     = 4;
  localparam int BIT_CCB     = 3;
  localparam int BIT_CCA     = 2;
  localparam int BIT_PTMR    = 1;
  localparam int BIT_WTMR    = 0;

  // global control bit positions
  localparam int BIT_GIE     = 1;
  localparam int BIT_PERIPHERAL_IRQ_ENABLE    = 0;

  // avalon slave request
  typedef struct packed {
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } av_req_t;

  // avalon slave answer
  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } av_rsp_t;

endpackage

// File: logic/sticky_flags.sv
// Purpose: eight sticky event flags, set by hardware, cleared by software
// Assumes: set pulses and clear masks are synchronous to clk
// Notes:   a set in the clear cycle wins
`timescale 1ns/1ps
`default_nettype none
module sticky_flags
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] set_pulse,
  input  wire logic [7:0] clr_mask,
  output logic      [7:0] flags
);

  // whole state in one struct
  typedef struct packed {
    logic [7:0] flags;
  } sticky_state_t;

  sticky_state_t st;
  sticky_state_t next_st;

  // set dominates clear
  always_comb
  begin
    next_st       = st;
    next_st.flags = (st.flags & ~clr_mask) | set_pulse;
  end

  // register the state
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign flags = st.flags;

endmodule
`default_nettype wire

// File: logic/av_slave.sv
// Purpose: Avalon-MM slave front end with one wait cycle per access
// Assumes: master holds its request until waitrequest is low
// Notes:   accept pulses are one cycle, at the edge that ends the access
`timescale 1ns/1ps
`default_nettype none
module av_slave
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire irq_regs_pkg::av_req_t req,
  output logic                       waitrequest,
  output logic                       wr_accept,
  output logic                       rd_accept
);

  // one bit of state: the access has waited one cycle
  typedef struct packed {
    logic armed;
  } slave_state_t;

  slave_state_t st;
  slave_state_t next_st;

  // arm on the first request cycle, drop on completion
  always_comb
  begin
    next_st       = st;
    next_st.armed = (req.read || req.write) && !st.armed;
  end

  // register the state
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st <= '0;
    else
      st <= next_st;
  end

  // waitrequest high until armed
  assign waitrequest = (req.read || req.write) ? !st.armed : 1'b0;
  assign wr_accept   = req.write && st.armed;
  assign rd_accept   = req.read && st.armed;

endmodule
`default_nettype wire

// File: logic/peripheral_irq_flag_enable_regs.sv
// Purpose: protection interrupt enables, serial/timer interrupt flags, peripheral request
// Assumes: peripheral event inputs are one-cycle pulses or levels on clk
// Notes:   registers are reached over Avalon-MM; each access takes two cycles
// Operation
// - bit 7 enables desaturation detect request
// - bit 6 enables converter done request
// - enable bit 5 absent, reads zero
// - bit 4 enables overtemperature request
// - bit 3 enables output overvoltage request
// - bit 2 enables gate drive undervoltage request
// - bit 1 enables input overvoltage request
// - bit 0 enables input undervoltage request
// - flags set regardless of any enable
// - tx flag high while tx empty, write clears
// - rx flag high while rx full, read clears
// - flag 5 shows bus collision pending
// - flag 4 shows serial port pending
// - flag 3 set by second capture/compare
// - flag 2 set by first capture/compare
// - flag 1 set by period timer match, sticky
// - flag 0 set by wide timer rollover, sticky
// - peripheral enable gates all peripheral requests
// - global enable gates every interrupt; the code gates peripheral_irq_req only, prot_irq_pending passes without it
//
// Our own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module peripheral_irq_flag_enable_regs
(
  input  wire logic                  clk,
  input  wire logic                  nrst,
  input  wire irq_regs_pkg::av_req_t av_req,
  output irq_regs_pkg::av_rsp_t      av_rsp,
  input  wire logic [7:0]            prot_event,
  input  wire logic                  serial_tx_empty,
  input  wire logic                  serial_rx_full,
  input  wire logic                  bus_collision_event,
  input  wire logic                  sync_serial_event,
  input  wire logic                  capcomp_b_event,
  input  wire logic                  capcomp_a_event,
  input  wire logic                  period_timer_match,
  input  wire logic                  wide_timer_rollover,
  input  wire logic                  tx_data_write,
  input  wire logic                  rx_data_read,
  output logic [7:0]                 prot_irq_pending,
  output logic                       peripheral_irq_req
);

  // reset synchroniser
  logic rst_meta;
  logic rst_n;

  // bus front end strobes
  logic waitrequest;
  logic wr_accept;
  logic rd_accept;

  // sticky flag interface
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  logic [7:0] sticky;

  // register state in one struct
  typedef struct packed {
    logic [7:0]  prot_en;
    logic [7:0]  ser_en;
    logic [1:0]  global_ctl;
    logic [31:0] rdata;
    logic        irq;
    logic [7:0]  prot_pend;
  } regs_state_t;

  regs_state_t st;
  regs_state_t next_st;

  // live serial/timer flag view: level flags follow their buffers
  logic [7:0] ser_flags;
  logic [7:0] prot_unmasked;
  logic       any_req;

  // decode helper
  function automatic logic hit(input logic [3:0] a, input logic [3:0] ref_addr);
    hit = (a == ref_addr);
  endfunction

  // release reset through two flops
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // bus handshake
  av_slave u_slave
  (
    .clk         (clk),
    .rst_n       (rst_n),
    .req         (av_req),
    .waitrequest (waitrequest),
    .wr_accept   (wr_accept),
    .rd_accept   (rd_accept)
  );

  // event sources into the sticky flags, independent of enables
  always_comb
  begin
    flag_set = 8'h00;
    flag_set[irq_regs_pkg::BIT_BCOL] = bus_collision_event;
    flag_set[irq_regs_pkg::BIT_SSP]  = sync_serial_event;
    flag_set[irq_regs_pkg::BIT_CCB]  = capcomp_b_event;
    flag_set[irq_regs_pkg::BIT_CCA]  = capcomp_a_event;
    flag_set[irq_regs_pkg::BIT_PTMR] = period_timer_match;
    flag_set[irq_regs_pkg::BIT_WTMR] = wide_timer_rollover;
    // software clears a sticky flag by writing 0 to it
    flag_clr = 8'h00;
    if (wr_accept && hit(av_req.address, irq_regs_pkg::ADDR_SER_FLAGS))
      flag_clr = ~av_req.writedata[7:0] & 8'h3F;
  end

  // sticky flags, set wins over clear
  sticky_flags u_flags
  (
    .clk       (clk),
    .rst_n     (rst_n),
    .set_pulse (flag_set),
    .clr_mask  (flag_clr),
    .flags     (sticky)
  );

  // status flags follow their buffers; the data write or read also clears them in its own cycle, ahead of the buffer
  always_comb
  begin
    ser_flags                          = sticky & 8'h3F;
    ser_flags[irq_regs_pkg::BIT_TX]    = serial_tx_empty && !tx_data_write;
    ser_flags[irq_regs_pkg::BIT_RX]    = serial_rx_full && !rx_data_read;
  end

  // enabled protection requests; bit 5 never passes
  assign prot_unmasked = prot_event & st.prot_en & irq_regs_pkg::PROT_EN_MASK;
  assign any_req       = (|(ser_flags & st.ser_en)) || (|prot_unmasked);

  // register file and request logic
  always_comb
  begin
    next_st           = st;
    next_st.prot_pend = prot_unmasked;
    // gate by peripheral then global enable
    next_st.irq = any_req && st.global_ctl[irq_regs_pkg::BIT_PERIPHERAL_IRQ_ENABLE]
                  && st.global_ctl[irq_regs_pkg::BIT_GIE];
    if (wr_accept)
    begin
      // writable registers
      if (hit(av_req.address, irq_regs_pkg::ADDR_PROT_EN))
        next_st.prot_en = av_req.writedata[7:0] & irq_regs_pkg::PROT_EN_MASK;
      else if (hit(av_req.address, irq_regs_pkg::ADDR_SER_EN))
        next_st.ser_en = av_req.writedata[7:0];
      else if (hit(av_req.address, irq_regs_pkg::ADDR_GLOBAL))
        next_st.global_ctl = av_req.writedata[1:0];
    end
    if (av_req.read && waitrequest)
    begin
      // capture the readback in the wait cycle so a flop holds it at the completing edge
      unique case (av_req.address)
        irq_regs_pkg::ADDR_PROT_EN:   next_st.rdata = {24'h000000, st.prot_en & irq_regs_pkg::PROT_EN_MASK};
        irq_regs_pkg::ADDR_SER_FLAGS: next_st.rdata = {24'h000000, ser_flags};
        irq_regs_pkg::ADDR_SER_EN:    next_st.rdata = {24'h000000, st.ser_en};
        irq_regs_pkg::ADDR_GLOBAL:    next_st.rdata = {30'h00000000, st.global_ctl};
        default:                      next_st.rdata = 32'h00000000;
      endcase
    end
    else if (rd_accept)
      next_st.rdata = 32'h00000000; // drop the word once the master has taken it
  end

  // register the state
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st            <= '0;
      st.prot_en    <= irq_regs_pkg::PROT_EN_RST;
      st.ser_en     <= irq_regs_pkg::SER_EN_RST;
      st.global_ctl <= irq_regs_pkg::GLOBAL_RST;
    end
    else
      st <= next_st;
  end

  // handshake straight from the front end, data from the captured word
  always_comb
  begin
    av_rsp.waitrequest = waitrequest;
    av_rsp.readdata    = st.rdata;
  end

  assign peripheral_irq_req = st.irq;
  assign prot_irq_pending   = st.prot_pend;

  // enable bit 5 never reads back as one
  AST_BIT5_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    !st.prot_en[5])
    else $error("protection enable bit 5 set");

  // a flag event shows one cycle later whatever the enables
  AST_FLAG_SET: assert property (@(posedge clk) disable iff (!rst_n)
    period_timer_match |=> sticky[irq_regs_pkg::BIT_PTMR])
    else $error("timer match flag not set");

  // a sticky flag holds without a clear
  AST_STICKY_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    sticky[0] && !flag_clr[0] |=> sticky[0])
    else $error("rollover flag dropped");

  // no request without peripheral enable
  AST_PERIPHERAL_IRQ_ENABLE_GATE: assert property (@(posedge clk) disable iff (!rst_n)
    !st.global_ctl[irq_regs_pkg::BIT_PERIPHERAL_IRQ_ENABLE] |=> !peripheral_irq_req)
    else $error("request without peripheral enable");

  // no request without global enable
  AST_GIE_GATE: assert property (@(posedge clk) disable iff (!rst_n)
    !st.global_ctl[irq_regs_pkg::BIT_GIE] |=> !peripheral_irq_req)
    else $error("request without global enable");

  // enabled desaturation_detect event raises the request
  AST_DESATURATION_DETECT_REQ: assert property (@(posedge clk) disable iff (!rst_n)
    prot_event[7] && st.prot_en[7] && (&st.global_ctl) |=> peripheral_irq_req)
    else $error("desaturation_detect request lost");

  // masked converter event gives no pending bit
  AST_CONV_MASK: assert property (@(posedge clk) disable iff (!rst_n)
    !st.prot_en[6] |=> !prot_irq_pending[6])
    else $error("masked converter request passed");

  // tx flag tracks buffer empty
  AST_TX_LEVEL: assert property (@(posedge clk) disable iff (!rst_n)
    ser_flags[7] == (serial_tx_empty && !tx_data_write))
    else $error("tx flag wrong");

  // a completed write into the protection enable register
  sequence prot_en_written_s;
    wr_accept && hit(av_req.address, irq_regs_pkg::ADDR_PROT_EN);
  endsequence

  // a completed write into the serial/timer flag register
  sequence flags_written_s;
    wr_accept && hit(av_req.address, irq_regs_pkg::ADDR_SER_FLAGS);
  endsequence

  // both global gates open
  sequence gates_open_s;
    st.global_ctl[irq_regs_pkg::BIT_GIE] && st.global_ctl[irq_regs_pkg::BIT_PERIPHERAL_IRQ_ENABLE];
  endsequence

  // an enable write lands with the absent bit dropped
  AST_EN_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
    prot_en_written_s |=> st.prot_en == ($past(av_req.writedata[7:0]) & irq_regs_pkg::PROT_EN_MASK))
    else $error("protection enable write wrong");

  // the absent position never shows a pending request
  AST_PEND_BIT5: assert property (@(posedge clk) disable iff (!rst_n)
    !prot_irq_pending[5])
    else $error("pending bit 5 set");

  // enabled overtemperature event passes to the pending bit
  AST_OTEMP_PASS: assert property (@(posedge clk) disable iff (!rst_n)
    st.prot_en[irq_regs_pkg::BIT_OTEMP] |=> prot_irq_pending[4] == $past(prot_event[4]))
    else $error("overtemperature request wrong");

  // enabled output overvoltage event passes to the pending bit
  AST_OUT_OV_PASS: assert property (@(posedge clk) disable iff (!rst_n)
    st.prot_en[irq_regs_pkg::BIT_OUT_OV] |=> prot_irq_pending[3] == $past(prot_event[3]))
    else $error("output overvoltage request wrong");

  // enabled gate drive undervoltage event passes to the pending bit
  AST_GD_UV_PASS: assert property (@(posedge clk) disable iff (!rst_n)
    st.prot_en[irq_regs_pkg::BIT_GD_UV] |=> prot_irq_pending[2] == $past(prot_event[2]))
    else $error("gate drive undervoltage request wrong");

  // enabled input overvoltage event passes to the pending bit
  AST_IN_OV_PASS: assert property (@(posedge clk) disable iff (!rst_n)
    st.prot_en[irq_regs_pkg::BIT_IN_OV] |=> prot_irq_pending[1] == $past(prot_event[1]))
    else $error("input overvoltage request wrong");

  // enabled input undervoltage event passes to the pending bit
  AST_IN_UV_PASS: assert property (@(posedge clk) disable iff (!rst_n)
    st.prot_en[irq_regs_pkg::BIT_IN_UV] |=> prot_irq_pending[0] == $past(prot_event[0]))
    else $error("input undervoltage request wrong");

  // a transmit data write hides the tx flag in that cycle
  AST_TX_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
    tx_data_write |-> !ser_flags[irq_regs_pkg::BIT_TX])
    else $error("tx flag not cleared by write");

  // rx flag shows a full receive buffer
  AST_RX_LEVEL: assert property (@(posedge clk) disable iff (!rst_n)
    serial_rx_full && !rx_data_read |-> ser_flags[irq_regs_pkg::BIT_RX])
    else $error("rx flag missing");

  // a receive data read hides the rx flag in that cycle
  AST_RX_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
    rx_data_read |-> !ser_flags[irq_regs_pkg::BIT_RX])
    else $error("rx flag not cleared by read");

  // bus collision event sets its flag
  AST_BCOL_SET: assert property (@(posedge clk) disable iff (!rst_n)
    bus_collision_event |=> sticky[irq_regs_pkg::BIT_BCOL])
    else $error("collision flag not set");

  // serial port event sets its flag
  AST_SSP_SET: assert property (@(posedge clk) disable iff (!rst_n)
    sync_serial_event |=> sticky[irq_regs_pkg::BIT_SSP])
    else $error("serial port flag not set");

  // second capture/compare event sets its flag
  AST_CCB_SET: assert property (@(posedge clk) disable iff (!rst_n)
    capcomp_b_event |=> sticky[irq_regs_pkg::BIT_CCB])
    else $error("second capture flag not set");

  // first capture/compare event sets its flag
  AST_CCA_SET: assert property (@(posedge clk) disable iff (!rst_n)
    capcomp_a_event |=> sticky[irq_regs_pkg::BIT_CCA])
    else $error("first capture flag not set");

  // writing zero with no new match clears the timer match flag
  AST_PTMR_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
    flags_written_s ##0 (!av_req.writedata[irq_regs_pkg::BIT_PTMR] && !period_timer_match)
    |=> !sticky[irq_regs_pkg::BIT_PTMR])
    else $error("timer match flag not cleared");

  // the timer match flag holds without a clear
  AST_PTMR_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    sticky[irq_regs_pkg::BIT_PTMR] && !flag_clr[irq_regs_pkg::BIT_PTMR] |=> sticky[irq_regs_pkg::BIT_PTMR])
    else $error("timer match flag dropped");

  // rollover sets its flag even against a clear
  AST_WTMR_SET: assert property (@(posedge clk) disable iff (!rst_n)
    wide_timer_rollover |=> sticky[irq_regs_pkg::BIT_WTMR])
    else $error("rollover flag not set");

  // an enabled serial/timer flag with open gates raises the request
  AST_REQ_RISE: assert property (@(posedge clk) disable iff (!rst_n)
    gates_open_s ##0 (|(ser_flags & st.ser_en)) |=> peripheral_irq_req)
    else $error("enabled flag gave no request");

  // no enabled source, no request
  AST_NO_SOURCE: assert property (@(posedge clk) disable iff (!rst_n)
    !any_req |=> !peripheral_irq_req)
    else $error("request without source");

endmodule
`default_nettype wire

// File: sim/periph_model.sv
// Purpose: peripheral side model, event pulses and serial buffers
// Assumes: commands come from the bench on clk
// Notes:   tx fills on a data write and drains on tx_sent; rx fills on rx_arrive and drains on a data read
`timescale 1ns/1ps
`default_nettype none
module periph_model
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [5:0] fire,
  input  wire logic       tx_write,
  input  wire logic       tx_sent,
  input  wire logic       rx_arrive,
  input  wire logic       rx_read,
  output logic      [5:0] ev,
  output logic            tx_empty,
  output logic            rx_full
);
  logic tx_full; // transmit buffer holds a byte
  assign tx_empty = ~tx_full;
  // events leave as one-cycle pulses; tx fills on a write, drains when sent; rx fills on arrival, drains on a read
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ev      <= 6'h00;
      tx_full <= 1'b0;
      rx_full <= 1'b0;
    end
    else
    begin
      ev <= fire;
      if (tx_write)
        tx_full <= 1'b1;
      else if (tx_sent)
        tx_full <= 1'b0;
      if (rx_arrive)
        rx_full <= 1'b1;
      else if (rx_read)
        rx_full <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: sim/peripheral_irq_flag_enable_regs_tb.sv
// Purpose: self-checking bench for the interrupt enable and flag registers
// Assumes: one wait cycle per bus access, registered request
// Notes:   a cycle ceiling cuts a hang short
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module peripheral_irq_flag_enable_regs_tb;
  logic                  clk = 1'b0;
  logic                  nrst;
  irq_regs_pkg::av_req_t av_req = '0;
  irq_regs_pkg::av_rsp_t av_rsp;
  logic [7:0]            prot_event = 8'h00;
  logic [5:0]            fire = 6'h00;
  logic [5:0]            ev;
  logic [3:0]            bcmd = 4'h0; // tx write, tx sent, rx arrive, rx read
  logic                  tx_empty;
  logic                  rx_full;
  logic [7:0]            prot_pend;
  logic                  req;
  logic [31:0]           rd; // data taken at the completing edge
  int                    num_errors = 0;
  int                    checked = 0;
  int                    cycles = 0;

  periph_model i_model (.clk(clk), .nrst(nrst), .fire(fire), .tx_write(bcmd[3]), .tx_sent(bcmd[2]),
    .rx_arrive(bcmd[1]), .rx_read(bcmd[0]), .ev(ev), .tx_empty(tx_empty), .rx_full(rx_full));
  peripheral_irq_flag_enable_regs i_dut (.clk(clk), .nrst(nrst), .av_req(av_req), .av_rsp(av_rsp),
    .prot_event(prot_event), .serial_tx_empty(tx_empty), .serial_rx_full(rx_full),
    .bus_collision_event(ev[5]), .sync_serial_event(ev[4]), .capcomp_b_event(ev[3]),
    .capcomp_a_event(ev[2]), .period_timer_match(ev[1]), .wide_timer_rollover(ev[0]),
    .tx_data_write(bcmd[3]), .rx_data_read(bcmd[0]), .prot_irq_pending(prot_pend),
    .peripheral_irq_req(req));

  always #5 clk = ~clk;

  // verdict and end of run
  task automatic end_of_test();
    $display("errors=%0d checks=%0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // one bus access held until waitrequest is seen low, then an idle cycle
  task automatic access(input logic w, input logic [3:0] a, input logic [7:0] d);
    av_req.address   <= a;
    av_req.write     <= w;
    av_req.read      <= ~w;
    av_req.writedata <= {24'h000000, d};
    do @(posedge clk); while (av_rsp.waitrequest !== 1'b0);
    rd = av_rsp.readdata;
    av_req.write <= 1'b0;
    av_req.read  <= 1'b0;
    @(posedge clk);
  endtask

  // read and compare the whole word, upper bits zero
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    access(1'b0, a, 8'h00);
    `CHK(rd, {24'h000000, e})
  endtask

  // event pulses and buffer commands for one cycle, then let them settle
  task automatic pulse(input logic [5:0] f, input logic [3:0] b);
    fire <= f;
    bcmd <= b;
    @(posedge clk);
    fire <= 6'h00;
    bcmd <= 4'h0;
    repeat (3) @(posedge clk);
  endtask

  // cycle ceiling against a hang
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      num_errors++;
      end_of_test();
    end
  end

  initial
  begin
    nrst <= 1'b0; // a real falling edge once every process waits on it
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    // reset values, empty transmit buffer shows at once, unmapped read
    rd_chk(irq_regs_pkg::ADDR_PROT_EN, 8'h00);
    rd_chk(irq_regs_pkg::ADDR_SER_FLAGS, 8'h80);
    rd_chk(irq_regs_pkg::ADDR_GLOBAL, 8'h00);
    rd_chk(irq_regs_pkg::ADDR_SER_EN, 8'h00);
    rd_chk(4'h1, 8'h00);
    // absent enable bit and an ignored unmapped write
    access(1'b1, irq_regs_pkg::ADDR_PROT_EN, 8'hFF);
    access(1'b1, 4'h2, 8'h00);
    rd_chk(irq_regs_pkg::ADDR_PROT_EN, 8'hDF);
    // each enable bit alone passes only its own protection event
    prot_event <= 8'hFF;
    for (int i = 0; i < 8; i++)
    begin
      access(1'b1, irq_regs_pkg::ADDR_PROT_EN, 8'h01 << i);
      repeat (2) @(posedge clk);
      `CHK(prot_pend, (8'h01 << i) & 8'hDF)
    end
    prot_event <= 8'h00;
    // each sticky flag set with serial/timer and global enables off, then cleared by a zero
    for (int i = 0; i < 6; i++)
    begin
      pulse(6'h01 << i, 4'h0);
      rd_chk(irq_regs_pkg::ADDR_SER_FLAGS, 8'h80 | (8'h01 << i));
      `CHK(req, 1'b0)
      access(1'b1, irq_regs_pkg::ADDR_SER_FLAGS, 8'h00);
    end
    // a one keeps a flag, a zero clears it
    pulse(6'h3F, 4'h0);
    access(1'b1, irq_regs_pkg::ADDR_SER_FLAGS, 8'h3E);
    rd_chk(irq_regs_pkg::ADDR_SER_FLAGS, 8'hBE);
    access(1'b1, irq_regs_pkg::ADDR_SER_FLAGS, 8'h00);
    rd_chk(irq_regs_pkg::ADDR_SER_FLAGS, 8'h80);
    // serial buffer levels drive the two live flags
    pulse(6'h00, 4'h8);
    rd_chk(irq_regs_pkg::ADDR_SER_FLAGS, 8'h00);
    pulse(6'h00, 4'h2);
    rd_chk(irq_regs_pkg::ADDR_SER_FLAGS, 8'h40);
    pulse(6'h00, 4'h1);
    rd_chk(irq_regs_pkg::ADDR_SER_FLAGS, 8'h00);
    // request gated by flag and enable, then by both global enables
    access(1'b1, irq_regs_pkg::ADDR_SER_EN, 8'h01);
    pulse(6'h01, 4'h0);
    for (int g = 0; g < 4; g++)
    begin
      access(1'b1, irq_regs_pkg::ADDR_GLOBAL, 8'(g));
      repeat (3) @(posedge clk);
      `CHK(req, (g == 3))
    end
    access(1'b1, irq_regs_pkg::ADDR_SER_FLAGS, 8'h00);
    pulse(6'h02, 4'h0);
    `CHK(req, 1'b0)
    // transmit empty again raises the request once enabled
    pulse(6'h00, 4'h4);
    access(1'b1, irq_regs_pkg::ADDR_SER_EN, 8'h80);
    repeat (3) @(posedge clk);
    `CHK(req, 1'b1)
    // a protection source alone raises the request through both gates
    access(1'b1, irq_regs_pkg::ADDR_SER_EN, 8'h00);
    repeat (3) @(posedge clk);
    `CHK(req, 1'b0)
    prot_event <= 8'h80;
    repeat (3) @(posedge clk);
    `CHK(req, 1'b1)
    `CHK(prot_pend, 8'h80)
    end_of_test();
  end
endmodule
`default_nettype wire
